// file: hdl/iorcr_regs.vh
`ifndef IORCR_REGS_VH
`define IORCR_REGS_VH
// window compare field of the 34-bit extended address
`define IORCR_WIN_HI        33
`define IORCR_WIN_LO        24
`define IORCR_WIN_W         10
`define IORCR_ADDR_W        34
// reset values of the configuration options
`define IORCR_WIN_RST       10'h000
`define IORCR_DEVID_RST     16'h00FF
// transaction type codes carried with each request
`define IORCR_TT_W          4
`define IORCR_TT_NWRITE     4'h0
`define IORCR_TT_SWRITE     4'h1
`define IORCR_TT_NWRITE_R   4'h2
`define IORCR_TT_NREAD      4'h3
`define IORCR_TT_DOORBELL   4'h4
`define IORCR_TT_ATOMIC     4'h5
`define IORCR_TT_MESSAGE    4'h6
`define IORCR_TT_PORTWRITE  4'h7
`define IORCR_TT_MAINT      4'h8
`define IORCR_TT_USER       4'hF
// destination codes
`define IORCR_DST_IO        2'h0
`define IORCR_DST_MAINT     2'h1
`define IORCR_DST_USER      2'h2
`define IORCR_DST_DROP      2'h3
`endif

// file: hdl/iorcr_router.v
`timescale 1ns/100ps
`default_nettype none
`include "iorcr_regs.vh"

module iorcr_router #(
   parameter       WIN_EN     = 1,        // window support option
   parameter       HDR_FMT    = 1,        // I/O port uses header-encoded format
   parameter       DEVID_16   = 0,        // 0: 8-bit IDs, 1: 16-bit IDs
   parameter [9:0] WIN_RST    = `IORCR_WIN_RST,
   parameter [15:0] DEVID_RST = `IORCR_DEVID_RST,
   parameter [7:0] SRC_EN     = 8'h7F,    // per type, bit = type code
   parameter [7:0] DST_EN     = 8'h7F
) (
   input  wire                     clk,
   input  wire                     arst_n,
   // request from the transport layer
   input  wire                     rx_valid,
   input  wire [`IORCR_ADDR_W-1:0] rx_addr,
   input  wire [`IORCR_TT_W-1:0]   rx_ttype,
   input  wire [15:0]              rx_dest_id,
   input  wire                     rx_raw_fmt,    // packet arrived as raw stream
   // register writes from configuration space
   input  wire                     win_base_wr,
   input  wire [`IORCR_WIN_W-1:0]  win_base_wdata,
   input  wire                     devid_wr,
   input  wire [15:0]              devid_wdata,
   // outbound request from user logic
   input  wire                     tx_valid,
   input  wire [`IORCR_TT_W-1:0]   tx_ttype,
   // routed output
   output reg                      io_valid_ff,
   output reg                      maint_valid_ff,
   output reg                      user_valid_ff,
   output reg                      out_raw_fmt_ff,
   output reg  [`IORCR_ADDR_W-1:0] out_addr_ff,
   output reg  [`IORCR_TT_W-1:0]   out_ttype_ff,
   output reg                      drop_ff,       // unsupported request dropped
   output reg                      hdr_codec_ff,  // conversion path active
   output reg                      tx_accept_ff,
   output reg                      tx_reject_ff,
   output reg                      id_match_ff,
   output reg  [`IORCR_WIN_W-1:0]  win_base_ff,
   output reg  [15:0]              devid_ff
);

   // true when the type code is enabled in the given enable vector
   function type_en;
      input [7:0]             en;
      input [`IORCR_TT_W-1:0] tt;
      begin
         type_en = (tt < 4'h8) ? en[tt[2:0]] : 1'b0;
      end
   endfunction

   reg  [1:0] nxt_dst;
   reg        nxt_hdr;
   wire       win_hit;
   wire       win_ok;
   wire       rx_sup;
   wire       id_hit;
   // decoded route strobes
   wire       to_io;
   wire       to_maint;
   wire       to_user;
   wire       to_drop;
   // outbound decode result
   wire       tx_ok_now;

   // port-write never counts as supported, whatever the enable vectors say
   assign rx_sup = type_en(DST_EN, rx_ttype) &&
                   (rx_ttype != `IORCR_TT_PORTWRITE);
   assign win_hit = (rx_addr[`IORCR_WIN_HI:`IORCR_WIN_LO] ==
                     win_base_ff);
   // window qualification; raw packets and disabled types never match
   assign win_ok = (WIN_EN != 0) && (HDR_FMT != 0) && !rx_raw_fmt &&
                   rx_sup;
   // 8-bit mode looks only at the low byte of the ID field
   assign id_hit = (DEVID_16 != 0) ? (rx_dest_id == devid_ff) :
                   (rx_dest_id[7:0] == devid_ff[7:0]);

   // route decision; window logic is skipped when support is off
   always @* begin
      nxt_dst = `IORCR_DST_IO;
      nxt_hdr = 1'b0;
      if (rx_ttype == `IORCR_TT_USER) begin
         nxt_dst = `IORCR_DST_USER;
      end else if (rx_ttype == `IORCR_TT_MAINT) begin
         nxt_dst = `IORCR_DST_MAINT;
      end else if (!rx_sup && (HDR_FMT != 0) && !rx_raw_fmt) begin
         // no decode path for a disabled type
         nxt_dst = `IORCR_DST_DROP;
      end else if (win_ok && win_hit) begin
         nxt_dst = `IORCR_DST_MAINT;
      end else begin
         // user logic must route a missed config access itself
         nxt_dst = `IORCR_DST_IO;
      end
      nxt_hdr = (HDR_FMT != 0) && !rx_raw_fmt && rx_sup &&
                (rx_ttype != `IORCR_TT_USER);
   end

   // one strobe per port; at most one is high for a given request
   assign to_io    = rx_valid && (nxt_dst == `IORCR_DST_IO);
   assign to_maint = rx_valid && (nxt_dst == `IORCR_DST_MAINT);
   assign to_user  = rx_valid && (nxt_dst == `IORCR_DST_USER);
   assign to_drop  = rx_valid && (nxt_dst == `IORCR_DST_DROP);

   // routed port pulses, one cycle after the request
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         io_valid_ff    <= 1'b0;
         maint_valid_ff <= 1'b0;
         user_valid_ff  <= 1'b0;
         drop_ff        <= 1'b0;
      end else begin
         io_valid_ff    <= to_io;
         maint_valid_ff <= to_maint;
         user_valid_ff  <= to_user;
         drop_ff        <= to_drop;
      end
   end

   // format and side flags of the routed packet
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         out_raw_fmt_ff <= 1'b0;
         hdr_codec_ff   <= 1'b0;
         id_match_ff    <= 1'b0;
      end else begin
         // user port carries raw stream, never header-encoded
         out_raw_fmt_ff <= (nxt_dst == `IORCR_DST_USER) ? 1'b1 :
                           !nxt_hdr;
         hdr_codec_ff   <= rx_valid && nxt_hdr;
         id_match_ff    <= rx_valid && id_hit;
      end
   end

   // request fields held until the next request replaces them
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         out_addr_ff  <= 34'h000000000;
         out_ttype_ff <= 4'h0;
      end else if (rx_valid) begin
         out_addr_ff  <= rx_addr;
         out_ttype_ff <= rx_ttype;
      end
   end

   // outbound decode: maintenance and user types always go out,
   // port-write never, the rest as the source enables say
   function tx_ok;
      input [7:0]             en;
      input [`IORCR_TT_W-1:0] tt;
      begin
         if (tt == `IORCR_TT_MAINT) begin
            tx_ok = 1'b1;
         end else if (tt == `IORCR_TT_USER) begin
            tx_ok = 1'b1;
         end else if (tt == `IORCR_TT_PORTWRITE) begin
            tx_ok = 1'b0;
         end else begin
            tx_ok = type_en(en, tt);
         end
      end
   endfunction

   // one decode feeds both flags, so exactly one rises per request
   assign tx_ok_now = tx_ok(SRC_EN, tx_ttype);

   // outbound accept flag
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         tx_accept_ff <= 1'b0;
      end else begin
         tx_accept_ff <= tx_valid && tx_ok_now;
      end
   end

   // outbound reject flag
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         tx_reject_ff <= 1'b0;
      end else begin
         tx_reject_ff <= tx_valid && !tx_ok_now;
      end
   end

   // window base; the option gives only the reset value
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         win_base_ff <= WIN_RST;
      end else if (win_base_wr) begin
         win_base_ff <= win_base_wdata;
      end
   end

   // base device ID; 8-bit mode keeps the upper byte clear so a
   // stale high byte can never break the low-byte compare
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         devid_ff <= DEVID_RST;
      end else if (devid_wr) begin
         devid_ff <= (DEVID_16 != 0) ? devid_wdata :
                     {8'h00, devid_wdata[7:0]};
      end
   end

endmodule // iorcr_router
`default_nettype wire

// file: bench/iorcr_user_model.sv
`timescale 1ns/100ps
`default_nettype none
// user logic sourcing outbound requests on the stream port
module iorcr_user_model (
   input wire logic        clk,
   output var logic        tx_valid,
   output var logic [3:0]  tx_ttype
);
   initial {tx_valid, tx_ttype} = 5'h00;
   // one-cycle request; type inverted after so stale values never match
   task send(input logic [3:0] t);
      @(negedge clk);
      {tx_ttype, tx_valid} = {t, 1'b1};
      @(negedge clk);
      {tx_ttype, tx_valid} = {~t, 1'b0};
   endtask
endmodule // iorcr_user_model
`default_nettype wire

// file: bench/iorcr_checker.sv
`timescale 1ns/100ps
`default_nettype none
`include "iorcr_regs.vh"
module iorcr_checker #(
   parameter [9:0]  WIN_RST   = 10'h000,
   parameter [15:0] DEVID_RST = 16'h00FF
) (
   input wire logic clk, arst_n, rx_valid, rx_raw_fmt, tx_valid,
   input wire logic [33:0] rx_addr,
   input wire logic [3:0]  rx_ttype, tx_ttype,
   input wire logic io_valid_ff, maint_valid_ff, user_valid_ff,
   input wire logic out_raw_fmt_ff, drop_ff, tx_accept_ff, tx_reject_ff,
   input wire logic [9:0]  win_base_ff,
   input wire logic [15:0] devid_ff
);
   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);
   // header-encoded read request, split by window hit
   wire rd = rx_valid && !rx_raw_fmt && rx_ttype == `IORCR_TT_NREAD;
   wire hit = rx_addr[33:24] == win_base_ff;
   a_win_hit_maint: assert property (rd && hit |=> maint_valid_ff && !io_valid_ff)
      else $error("window hit not routed to maint");
   a_win_miss_io: assert property (rd && !hit |=> io_valid_ff)
      else $error("window miss not routed to io");
   a_raw_stays_io: assert property (rx_valid && rx_raw_fmt && rx_ttype == `IORCR_TT_NREAD |=> io_valid_ff && !maint_valid_ff)
      else $error("raw request rerouted");
   a_pw_rx_drop: assert property (rx_valid && !rx_raw_fmt && rx_ttype == `IORCR_TT_PORTWRITE |=> drop_ff)
      else $error("port-write not dropped");
   a_pw_tx_reject: assert property (tx_valid && tx_ttype == `IORCR_TT_PORTWRITE |=> tx_reject_ff && !tx_accept_ff)
      else $error("port-write tx accepted");
   a_maint_tx_ok: assert property (tx_valid && tx_ttype == `IORCR_TT_MAINT |=> tx_accept_ff)
      else $error("maint tx refused");
   a_user_raw_fmt: assert property (user_valid_ff |-> out_raw_fmt_ff)
      else $error("user port not raw");
   a_reset_values: assert property ($rose(arst_n) |-> win_base_ff == WIN_RST && devid_ff == DEVID_RST)
      else $error("bad register reset value");
endmodule // iorcr_checker
bind iorcr_router iorcr_checker #(.WIN_RST(WIN_RST), .DEVID_RST(DEVID_RST)) i_iorcr_checker (
   .clk(clk), .arst_n(arst_n), .rx_valid(rx_valid), .rx_raw_fmt(rx_raw_fmt),
   .tx_valid(tx_valid), .rx_addr(rx_addr), .rx_ttype(rx_ttype),
   .tx_ttype(tx_ttype), .io_valid_ff(io_valid_ff),
   .maint_valid_ff(maint_valid_ff), .user_valid_ff(user_valid_ff),
   .out_raw_fmt_ff(out_raw_fmt_ff), .drop_ff(drop_ff),
   .tx_accept_ff(tx_accept_ff), .tx_reject_ff(tx_reject_ff),
   .win_base_ff(win_base_ff), .devid_ff(devid_ff));
`default_nettype wire

// file: bench/tb_iorcr_router.sv
`timescale 1ns/100ps
`default_nettype none
`include "iorcr_regs.vh"
module tb_iorcr_router;
   logic clk = 0, arst_n = 0, rx_valid = 0, raw = 0, wb_wr = 0, id_wr = 0;
   logic [33:0] addr = 0, out_addr;
   logic [3:0]  tt = 0, tx_tt, out_tt;
   logic [15:0] dest = 0, id_wd = 0, devid;
   logic [9:0]  wb_wd = 0, wbase;
   logic tx_v, io, mt, us, raw_o, drop, codec, acc, rej, idm;
   int err_total = 0, n_tests = 0, cyc = 0;
   wire [3:0] route = {drop, mt, io, us};
   always #50 clk = ~clk;
   iorcr_router i_iorcr_router (.clk(clk), .arst_n(arst_n),
      .rx_valid(rx_valid), .rx_addr(addr), .rx_ttype(tt), .rx_dest_id(dest),
      .rx_raw_fmt(raw), .win_base_wr(wb_wr), .win_base_wdata(wb_wd),
      .devid_wr(id_wr), .devid_wdata(id_wd), .tx_valid(tx_v),
      .tx_ttype(tx_tt), .io_valid_ff(io), .maint_valid_ff(mt),
      .user_valid_ff(us), .out_raw_fmt_ff(raw_o), .out_addr_ff(out_addr),
      .out_ttype_ff(out_tt), .drop_ff(drop), .hdr_codec_ff(codec),
      .tx_accept_ff(acc), .tx_reject_ff(rej), .id_match_ff(idm),
      .win_base_ff(wbase), .devid_ff(devid));
   iorcr_user_model i_iorcr_user_model (.clk(clk), .tx_valid(tx_v),
      .tx_ttype(tx_tt));
   task chk(input string n, input logic [33:0] e, g);
      n_tests++;
      if (g !== e) begin
         err_total++;
         $display("MISMATCH %s exp %h got %h", n, e, g);
      end
   endtask
   task test_done;
      if (err_total == 0 && n_tests > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // one request pulse; results settled at the following falling edge
   task rx(input logic [33:0] a, input logic [3:0] t, input logic r);
      @(negedge clk);
      {addr, tt, raw, rx_valid} = {a, t, r, 1'b1};
      @(negedge clk) rx_valid = 0;
   endtask
   task t_window;
      {wb_wd, wb_wr} = {10'h3FF, 1'b1};
      @(negedge clk) wb_wr = 0;
      rx(34'h3FF000010, `IORCR_TT_NREAD, 0);
      chk("route", 4'h4, route);
      chk("codec", 1, codec);
      chk("addr", 34'h3FF000010, out_addr);
      rx(34'h1FF000010, `IORCR_TT_NREAD, 0);
      chk("route", 4'h2, route);
      rx(34'h3FF000010, `IORCR_TT_NREAD, 1);
      chk("route", 4'h2, route);
      chk("codec", 0, codec);
   endtask
   task t_types;
      for (int t = 0; t < 7; t++) begin
         rx(34'h3FF000000, t[3:0], 0);
         chk("route", 4'h4, route);
      end
      rx(34'h3FF000000, `IORCR_TT_PORTWRITE, 0);
      chk("route", 4'h8, route);
      chk("tt", `IORCR_TT_PORTWRITE, out_tt);
      rx(34'h3FF000000, `IORCR_TT_USER, 0);
      chk("route", 4'h1, route);
      chk("raw", 1, raw_o);
   endtask
   task t_tx;
      i_iorcr_user_model.send(`IORCR_TT_PORTWRITE);
      chk("rej", 1, rej);
      i_iorcr_user_model.send(`IORCR_TT_MAINT);
      chk("acc", 1, acc);
   endtask
   task t_devid;
      {id_wd, id_wr, dest} = {16'hAB12, 1'b1, 16'h0012};
      @(negedge clk) id_wr = 0;
      chk("devid", 16'h0012, devid);
      rx(0, `IORCR_TT_NREAD, 0);
      chk("idm", 1, idm);
   endtask
   initial begin
      repeat (10) @(negedge clk);
      arst_n = 1;
      chk("wbase", 10'h000, wbase);
      chk("devid", 16'h00FF, devid);
      t_window;
      t_types;
      t_tx;
      t_devid;
      test_done;
   end
   // hang guard, far above the few dozen cycles the run needs
   always @(posedge clk) if (++cyc == 2000) begin
      err_total++;
      test_done;
   end
endmodule // tb_iorcr_router
`default_nettype wire
